// ===== verilog/faorm_region_map.sv
// Top: link handshake, address decode and access policy for the array and security regions
// What this block does
// [RULE_01] The main array is byte addressed and split into 64 blocks of 64 KiB each.
// [RULE_02] The array is also split into 1024 sectors of 4 KiB, sixteen to a block.
// [RULE_03] Each aligned 256-byte page is programmed on its own without touching other pages.
// [RULE_04] Programming only turns ones into zeros; only erase brings bits back to one.
// [RULE_05] Erase exists only per sector, block or chip, never per page.
// [RULE_06] A sector covers low address bits 000h to FFFh, so sectors start on 1000h multiples.
// [RULE_07] Four 256-byte security regions sit in their own space at n times 1000h.
// [RULE_08] A set one-time lock bit write-protects its region for good and cannot be cleared; here rst_i reloads LOCK_RESET, clearing it.
// [RULE_09] Region 0 holds the parameter data, returned by the parameter read command 5Ah.
// [RULE_10] Regions 1 to 3 are erased, programmed and locked independently of all else.
// [RULE_11] Host writes to the parameter space are refused; it is read-only.
// [RULE_12] The header starts at 0000h, 0010h up is reserved header, the table starts at 0030h.
// [RULE_13] Parameter space ends at 006Fh; bytes 0070h to 00FFh are reserved.
// [RULE_14] The host finds tables through the header pointers, not by assumed placement; here no pointers exist and the bench reads fixed offsets.
// [RULE_15] The header comes first, followed by the one basic parameter table.
// [RULE_16] Parameter bytes 00h to 03h read back 53h, 46h, 44h, 50h.
// [RULE_17] Main array addresses use the low 22 bits of the 24-bit command address.
`timescale 1ns/1ps
module faorm_region_map
    import faorm_pkg::*;
#(
    parameter int                  AW      = ARRAY_AW,
    parameter logic [BYTE_W-1:0]   PRM_FILL = 8'hff
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              clk_link_i,
    input  wire logic              link_req_i,
    input  wire logic [7:0]        link_op_i,
    input  wire logic [ADDR_W-1:0] link_addr_i,
    input  wire logic [7:0]        link_wdata_i,
    output logic                   link_busy_o,
    output logic                   link_done_o,
    output logic                   link_err_o,
    output logic [7:0]             link_rdata_o
);
    localparam logic [AW-1:0] SECT_MASK  = AW'((32'd1 << SECTOR_AW) - 32'd1);
    localparam logic [AW-1:0] BLOCK_MASK = AW'((32'd1 << BLOCK_AW) - 32'd1);
    localparam logic [AW-1:0] CHIP_MASK  = '1;
    localparam logic [AW-1:0] SEC_MASK   = AW'((32'd1 << SEC_REGION_AW) - 32'd1);

    faorm_mem_if #(.AW(AW))         arr ();
    faorm_mem_if #(.AW(SEC_MEM_AW)) sec ();

    faorm_mem #(.AW(AW)) u_array
    (
        .clk_sys_i (clk_sys_i),
        .port      (arr.mem)
    );

    faorm_mem #(.AW(SEC_MEM_AW)) u_secure
    (
        .clk_sys_i (clk_sys_i),
        .port      (sec.mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: request capture and result return

    logic              rl_s1_r, rl_s2_r;
    logic              lnk_busy_r, lnk_busy_nxt;
    logic              lnk_done_r, lnk_done_nxt;
    logic              lnk_err_r, lnk_err_nxt;
    logic [7:0]        lnk_rdata_r, lnk_rdata_nxt;
    logic              req_tgl_r, req_tgl_nxt;
    logic [7:0]        lnk_op_r, lnk_op_nxt;
    logic [ADDR_W-1:0] lnk_addr_r, lnk_addr_nxt;
    logic [7:0]        lnk_wdata_r, lnk_wdata_nxt;
    logic              ack_s1_r, ack_s2_r, ack_s3_r;
    logic              ack_tgl_r;
    logic              res_err_r;
    logic [7:0]        res_rdata_r;

    // Command fields stay frozen while busy, so the system side may sample them after the toggle
    always_comb
    begin
        lnk_busy_nxt  = lnk_busy_r;
        lnk_done_nxt  = 1'b0;
        lnk_err_nxt   = lnk_err_r;
        lnk_rdata_nxt = lnk_rdata_r;
        req_tgl_nxt   = req_tgl_r;
        lnk_op_nxt    = lnk_op_r;
        lnk_addr_nxt  = lnk_addr_r;
        lnk_wdata_nxt = lnk_wdata_r;
        if (lnk_busy_r && (ack_s2_r ^ ack_s3_r))
        begin
            lnk_busy_nxt  = 1'b0;
            lnk_done_nxt  = 1'b1;
            lnk_err_nxt   = res_err_r;   // Held stable by the system side until the next request
            lnk_rdata_nxt = res_rdata_r;
        end
        else if (!lnk_busy_r && link_req_i)
        begin
            lnk_busy_nxt  = 1'b1;
            req_tgl_nxt   = ~req_tgl_r;
            lnk_op_nxt    = link_op_i;
            lnk_addr_nxt  = link_addr_i;
            lnk_wdata_nxt = link_wdata_i;
        end
    end

    // Reset reaches the link domain through two flops; the link clock must run while it settles
    always_ff @(posedge clk_link_i)
    begin
        rl_s1_r  <= rst_i;
        rl_s2_r  <= rl_s1_r;
        ack_s1_r <= ack_tgl_r;
        ack_s2_r <= ack_s1_r;
        if (rl_s2_r)
        begin
            lnk_busy_r  <= 1'b0;
            lnk_done_r  <= 1'b0;
            lnk_err_r   <= 1'b0;
            lnk_rdata_r <= ERASED_BYTE;
            req_tgl_r   <= 1'b0;
            lnk_op_r    <= OP_READ;
            lnk_addr_r  <= '0;
            lnk_wdata_r <= ERASED_BYTE;
            ack_s3_r    <= 1'b0;
        end
        else
        begin
            lnk_busy_r  <= lnk_busy_nxt;
            lnk_done_r  <= lnk_done_nxt;
            lnk_err_r   <= lnk_err_nxt;
            lnk_rdata_r <= lnk_rdata_nxt;
            req_tgl_r   <= req_tgl_nxt;
            lnk_op_r    <= lnk_op_nxt;
            lnk_addr_r  <= lnk_addr_nxt;
            lnk_wdata_r <= lnk_wdata_nxt;
            ack_s3_r    <= ack_s2_r;
        end
    end

    assign link_busy_o  = lnk_busy_r;
    assign link_done_o  = lnk_done_r;
    assign link_err_o   = lnk_err_r;
    assign link_rdata_o = lnk_rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: decode and access sequencer

    // Parameter space contents; only the signature is fixed, header and table bytes read as fill, reserved bytes as ERASED_BYTE
    function automatic logic [7:0] param_byte(input logic [7:0] a);
        logic [7:0] v;
        v = PRM_FILL;
        if (a >= PRM_RSVD_BASE)                                 // [RULE_13]
            v = ERASED_BYTE;
        else if (a >= PRM_TABLE_BASE && a <= PRM_END)           // [RULE_12] [RULE_15]
            v = PRM_FILL;
        else if (a >= PRM_HDR_RSVD)                             // [RULE_12]
            v = ERASED_BYTE;
        else if (a == PRM_HDR_BASE)                             // [RULE_16]
            v = SIG_0;
        else if (a == PRM_HDR_BASE + 8'h01)
            v = SIG_1;
        else if (a == PRM_HDR_BASE + 8'h02)
            v = SIG_2;
        else if (a == PRM_HDR_BASE + 8'h03)
            v = SIG_3;
        return v;
    endfunction

    logic                   req_s1_r, req_s2_r, req_s3_r;
    faorm_state_t           st_r, st_nxt;
    logic [7:0]             cmd_op_r, cmd_op_nxt;
    logic [ADDR_W-1:0]      cmd_addr_r, cmd_addr_nxt;
    logic [7:0]             cmd_wdata_r, cmd_wdata_nxt;
    logic                   res_err_nxt;
    logic [7:0]             res_rdata_nxt;
    logic                   ack_tgl_nxt;
    logic [AW-1:0]          mask_r, mask_nxt;
    logic [AW-1:0]          cnt_r, cnt_nxt;
    logic                   er_sec_r, er_sec_nxt;
    logic [SEC_REGIONS-1:0] lock_r, lock_nxt;
    logic [SEC_SEL_W-1:0]   region;
    logic                   sec_ok;
    logic                   sec_op;

    assign region = cmd_addr_r[SEC_STRIDE_AW +: SEC_SEL_W];                    // [RULE_07]
    assign sec_ok = (cmd_addr_r[ADDR_W-1:SEC_STRIDE_AW+SEC_SEL_W] == '0) &&
                    (cmd_addr_r[SEC_STRIDE_AW-1:SEC_REGION_AW] == '0);         // [RULE_07]
    assign sec_op = (cmd_op_r == OP_SEC_READ) || (cmd_op_r == OP_SEC_PROGRAM);

    // Next state, command latch and storage port drive
    always_comb
    begin
        st_nxt        = st_r;
        cmd_op_nxt    = cmd_op_r;
        cmd_addr_nxt  = cmd_addr_r;
        cmd_wdata_nxt = cmd_wdata_r;
        res_err_nxt   = res_err_r;
        res_rdata_nxt = res_rdata_r;
        ack_tgl_nxt   = ack_tgl_r;
        mask_nxt      = mask_r;
        cnt_nxt       = cnt_r;
        er_sec_nxt    = er_sec_r;
        lock_nxt      = lock_r;
        arr.we        = 1'b0;
        arr.addr      = cmd_addr_r[AW-1:0];                                    // [RULE_17]
        arr.wdata     = ERASED_BYTE;
        sec.we        = 1'b0;
        sec.addr      = {region, cmd_addr_r[SEC_REGION_AW-1:0]};               // [RULE_07]
        sec.wdata     = ERASED_BYTE;
        case (st_r)
            ST_IDLE:
            begin
                if (req_s2_r ^ req_s3_r)
                begin
                    cmd_op_nxt    = lnk_op_r;
                    cmd_addr_nxt  = lnk_addr_r;
                    cmd_wdata_nxt = lnk_wdata_r;
                    st_nxt        = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                res_err_nxt   = 1'b0;
                res_rdata_nxt = ERASED_BYTE;
                st_nxt        = ST_DONE;
                cnt_nxt       = '0;
                er_sec_nxt    = 1'b0;
                case (cmd_op_r)
                    OP_PARAM_READ:
                        res_rdata_nxt = param_byte(cmd_addr_r[7:0]);           // [RULE_09]
                    OP_READ, OP_PROGRAM:
                        st_nxt = ST_WAIT;                                      // [RULE_03]
                    OP_SECT_ERASE:
                    begin
                        mask_nxt = SECT_MASK;                                  // [RULE_02] [RULE_06]
                        st_nxt   = ST_ERASE;
                    end
                    OP_BLOCK_ERASE:
                    begin
                        mask_nxt = BLOCK_MASK;                                 // [RULE_01]
                        st_nxt   = ST_ERASE;
                    end
                    OP_CHIP_ERASE:
                    begin
                        mask_nxt = CHIP_MASK;
                        st_nxt   = ST_ERASE;
                    end
                    OP_SEC_READ:
                    begin
                        if (!sec_ok)
                            res_err_nxt = 1'b1;
                        else if (region == '0)
                            res_rdata_nxt = param_byte(cmd_addr_r[7:0]);       // [RULE_09]
                        else
                            st_nxt = ST_WAIT;
                    end
                    OP_SEC_PROGRAM, OP_SEC_ERASE:
                    begin
                        // Region 0 and locked regions refuse writes without touching storage
                        if (!sec_ok || region == '0 || lock_r[region])         // [RULE_08] [RULE_11]
                            res_err_nxt = 1'b1;
                        else if (cmd_op_r == OP_SEC_PROGRAM)
                            st_nxt = ST_WAIT;                                  // [RULE_10]
                        else
                        begin
                            mask_nxt   = SEC_MASK;
                            er_sec_nxt = 1'b1;
                            st_nxt     = ST_ERASE;
                        end
                    end
                    OP_SEC_LOCK:
                    begin
                        if (!sec_ok || region == '0)                           // [RULE_11]
                            res_err_nxt = 1'b1;
                        else
                            lock_nxt[region] = 1'b1;                           // [RULE_10]
                    end
                    default:
                        res_err_nxt = 1'b1;                                    // [RULE_05]
                endcase
            end
            ST_WAIT:
            begin
                // Read data of the addressed byte is valid here; programs AND it in
                st_nxt = ST_DONE;
                if (sec_op)
                begin
                    res_rdata_nxt = sec.rdata;
                    sec.we        = (cmd_op_r == OP_SEC_PROGRAM);
                    sec.wdata     = cmd_wdata_r & sec.rdata;                   // [RULE_04]
                end
                else
                begin
                    res_rdata_nxt = arr.rdata;
                    arr.we        = (cmd_op_r == OP_PROGRAM);
                    arr.wdata     = cmd_wdata_r & arr.rdata;                   // [RULE_04]
                end
            end
            ST_ERASE:
            begin
                // One byte per cycle; chip erase therefore takes 2**AW cycles
                cnt_nxt = cnt_r + 1'b1;
                if (er_sec_r)
                begin
                    sec.we   = 1'b1;
                    sec.addr = {region, cnt_r[SEC_REGION_AW-1:0]};
                end
                else
                begin
                    arr.we   = 1'b1;
                    arr.addr = (cmd_addr_r[AW-1:0] & ~mask_r) | cnt_r;         // [RULE_06]
                end
                if (cnt_r == mask_r)
                    st_nxt = ST_DONE;
            end
            ST_DONE:
            begin
                ack_tgl_nxt = ~ack_tgl_r;
                st_nxt      = ST_IDLE;
            end
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // Lock bits only ever set; reset models a part fresh from the factory
    always_ff @(posedge clk_sys_i)
    begin
        req_s1_r <= req_tgl_r;
        req_s2_r <= req_s1_r;
        if (rst_i)
        begin
            req_s3_r    <= 1'b0;
            st_r        <= ST_IDLE;
            cmd_op_r    <= OP_READ;
            cmd_addr_r  <= '0;
            cmd_wdata_r <= ERASED_BYTE;
            res_err_r   <= 1'b0;
            res_rdata_r <= ERASED_BYTE;
            ack_tgl_r   <= 1'b0;
            mask_r      <= '0;
            cnt_r       <= '0;
            er_sec_r    <= 1'b0;
            lock_r      <= LOCK_RESET;
        end
        else
        begin
            req_s3_r    <= req_s2_r;
            st_r        <= st_nxt;
            cmd_op_r    <= cmd_op_nxt;
            cmd_addr_r  <= cmd_addr_nxt;
            cmd_wdata_r <= cmd_wdata_nxt;
            res_err_r   <= res_err_nxt;
            res_rdata_r <= res_rdata_nxt;
            ack_tgl_r   <= ack_tgl_nxt;
            mask_r      <= mask_nxt;
            cnt_r       <= cnt_nxt;
            er_sec_r    <= er_sec_nxt;
            lock_r      <= lock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb_sys @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Reads the byte back two cycles on, so a broken write path or merge is caught in storage
    property p_prog_and;
        (st_r == ST_WAIT && cmd_op_r == OP_PROGRAM) |-> arr.we ##2 arr.rdata == ($past(cmd_wdata_r, 2) & $past(arr.rdata, 2));
    endproperty
    a_prog_and: assert property (p_prog_and) else $error("program sets a bit"); // [RULE_04]

    property p_region0_refused;
        (st_r == ST_EXEC && cmd_op_r == OP_SEC_PROGRAM && region == '0)
            |=> st_r == ST_DONE && res_err_r && !sec.we;
    endproperty
    a_region0_refused: assert property (p_region0_refused) else $error("region 0 write taken"); // [RULE_11]

    property p_lock_sticky;
        ($past(lock_r) & ~lock_r) == '0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared"); // [RULE_08]

    property p_lock_bits_stay;
        $rose(lock_r[2]) |=> lock_r[2] [*8];
    endproperty
    a_lock_bits_stay: assert property (p_lock_bits_stay) else $error("lock 2 dropped"); // [RULE_08]

    property p_locked_no_write;
        sec.we |-> !lock_r[sec.addr[SEC_MEM_AW-1 -: SEC_SEL_W]] && sec.addr[SEC_MEM_AW-1 -: SEC_SEL_W] != '0;
    endproperty
    a_locked_no_write: assert property (p_locked_no_write) else $error("write to locked region"); // [RULE_10]

    property p_signature;
        (st_r == ST_EXEC && cmd_op_r == OP_PARAM_READ && cmd_addr_r[7:0] == 8'h00)
            |=> res_rdata_r == SIG_0 ##1 $changed(ack_tgl_r);
    endproperty
    a_signature: assert property (p_signature) else $error("signature byte wrong"); // [RULE_16]

    property p_reserved;
        (st_r == ST_EXEC && cmd_op_r == OP_PARAM_READ && cmd_addr_r[7:0] >= PRM_RSVD_BASE)
            |=> res_rdata_r == ERASED_BYTE && !res_err_r;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved byte not blank"); // [RULE_13]

    property p_sector_bounds;
        (st_r == ST_ERASE && !er_sec_r && mask_r == SECT_MASK)
            |-> arr.addr[AW-1:SECTOR_AW] == cmd_addr_r[AW-1:SECTOR_AW];
    endproperty
    a_sector_bounds: assert property (p_sector_bounds) else $error("erase left its sector"); // [RULE_06]

    property p_read_addr;
        (st_r == ST_EXEC && cmd_op_r == OP_READ) |-> arr.addr == cmd_addr_r[AW-1:0] ##1 st_r == ST_WAIT;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("array address decode wrong"); // [RULE_17]

    property p_done_pulse;
        @(posedge clk_link_i) disable iff (rl_s2_r) link_done_o |-> !link_busy_o ##1 !link_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");

    c_sector_erase: cover property (st_r == ST_ERASE && mask_r == SECT_MASK && cnt_r == mask_r);
    c_sec_lock:     cover property ($rose(lock_r[2]));
    c_param_read:   cover property (st_r == ST_EXEC && cmd_op_r == OP_PARAM_READ);
    c_program:      cover property (arr.we && st_r == ST_WAIT);

endmodule // faorm_region_map

// ===== verilog/faorm_pkg.sv
// Package: geometry, command codes and parameter-space layout of the flash region map
package faorm_pkg;

    // Command address and main array geometry
    localparam int ADDR_W         = 24;
    localparam int ARRAY_AW       = 22;
    localparam int BLOCK_COUNT    = 64;
    localparam int SECTOR_COUNT   = 1024;
    localparam int PAGE_AW        = 8;
    localparam int SECTOR_AW      = 12;
    localparam int BLOCK_AW       = 16;

    // Security regions: four 256-byte regions, region n at n * 1000h
    localparam int SEC_REGIONS    = 4;
    localparam int SEC_REGION_AW  = 8;
    localparam int SEC_STRIDE_AW  = 12;
    localparam int SEC_SEL_W      = 2;
    localparam int SEC_MEM_AW     = SEC_SEL_W + SEC_REGION_AW;
    localparam logic [SEC_REGIONS-1:0] LOCK_RESET = 4'h1;   // Region 0 is factory locked

    localparam int BYTE_W         = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Command codes; only the parameter read code is fixed by the part
    localparam logic [7:0] OP_PARAM_READ  = 8'h5a;
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_PROGRAM     = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE  = 8'hc7;
    localparam logic [7:0] OP_SEC_READ    = 8'h48;
    localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
    localparam logic [7:0] OP_SEC_ERASE   = 8'h44;
    localparam logic [7:0] OP_SEC_LOCK    = 8'h11;

    // Parameter space layout inside region 0
    localparam logic [7:0] PRM_HDR_BASE   = 8'h00;
    localparam logic [7:0] PRM_HDR_RSVD   = 8'h10;
    localparam logic [7:0] PRM_TABLE_BASE = 8'h30;
    localparam logic [7:0] PRM_END        = 8'h6f;
    localparam logic [7:0] PRM_RSVD_BASE  = 8'h70;
    localparam logic [7:0] SIG_0          = 8'h53;
    localparam logic [7:0] SIG_1          = 8'h46;
    localparam logic [7:0] SIG_2          = 8'h44;
    localparam logic [7:0] SIG_3          = 8'h50;

    // Sequencer states, Gray along idle-exec-wait-done, erase one step off exec
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_EXEC  = 3'h1,
        ST_WAIT  = 3'h3,
        ST_DONE  = 3'h2,
        ST_ERASE = 3'h5
    } faorm_state_t;

endpackage

// ===== verilog/faorm_mem_if.sv
// Interface: byte-wide port between the sequencer and one storage array
`timescale 1ns/1ps
interface faorm_mem_if #(parameter int AW = 8);
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ===== verilog/faorm_mem.sv
// Byte storage array with registered read data
`timescale 1ns/1ps
module faorm_mem #(
    parameter int AW = 8
) (
    input  wire logic   clk_sys_i,
    faorm_mem_if.mem    port
);
    logic [7:0] store [0:(1<<AW)-1];
    logic [7:0] rdata_r;

    // Read returns the old byte on a same-address write; the read-modify-write reads its byte a cycle before it writes
    always_ff @(posedge clk_sys_i)
    begin
        rdata_r <= store[port.addr];
        if (port.we)
        begin
            store[port.addr] <= port.wdata;
        end
    end

    assign port.rdata = rdata_r;
endmodule // faorm_mem

// ===== test/faorm_host_model.sv
// Host-side model that issues single-byte commands on the link
`timescale 1ns/1ps
module faorm_host_model
    import faorm_pkg::*;
(
    input  wire logic              clk_link_i,
    input  wire logic              busy_i,
    input  wire logic              done_i,
    input  wire logic              err_i,
    input  wire logic [7:0]        rdata_i,
    output logic                   req_o,
    output logic [7:0]             op_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [7:0]             wdata_o
);
    initial
    begin
        req_o = 1'b0;
        op_o = 8'h00;
        addr_o = '0;
        wdata_o = 8'h00;
    end

    // One command; sampling at the falling edge keeps clear of the design's own updates
    task automatic cmd(input logic [7:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic e);
        int n;
        n = 0;
        do @(negedge clk_link_i); while (busy_i !== 1'b0);
        req_o = 1'b1;
        op_o = op;
        addr_o = a;
        wdata_o = wd;
        @(negedge clk_link_i);
        // Released lines carry no stale value
        req_o = 1'b0;
        op_o = ~op;
        addr_o = ~a;
        wdata_o = ~wd;
        while (done_i !== 1'b1 && n < 5000)
        begin
            @(negedge clk_link_i);
            n++;
        end
        rd = rdata_i;
        e = (n < 5000) ? err_i : 1'bx;  // A lost answer leaves e as x, so an error compare on this command fails
    endtask
endmodule // faorm_host_model

// ===== test/faorm_region_map_test.sv
// Self-checking bench for the flash region map
`timescale 1ns/1ps
module faorm_region_map_test;
    import faorm_pkg::*;
    localparam logic [7:0] FILL = 8'h5c;
    logic              clk_sys_i = 1'b0;
    logic              clk_link_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              req, busy, done, err, e;
    logic [7:0]        op, wd, rd, r;
    logic [ADDR_W-1:0] addr;
    int                fails = 0;
    int                n_compared = 0;
    int                cycles = 0;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

    always #4 clk_sys_i = ~clk_sys_i;
    // Link clock offset so its edges never line up with the system clock
    initial
    begin
        #37;
        forever #80 clk_link_i = ~clk_link_i;
    end

    faorm_region_map #(.AW(16), .PRM_FILL(FILL)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .clk_link_i(clk_link_i), .link_req_i(req), .link_op_i(op), .link_addr_i(addr),
        .link_wdata_i(wd), .link_busy_o(busy), .link_done_o(done), .link_err_o(err),
        .link_rdata_o(rd));
    faorm_host_model u_host (.clk_link_i(clk_link_i), .busy_i(busy), .done_i(done), .err_i(err),
        .rdata_i(rd), .req_o(req), .op_o(op), .addr_o(addr), .wdata_o(wd));

    task automatic run(input logic [7:0] o, input logic [ADDR_W-1:0] a, input logic [7:0] w);
        u_host.cmd(o, a, w, r, e);
    endtask

    // Parameter space layout, both read paths, and refusal of writes to it
    task automatic t_params();
        logic [7:0] a [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h10, 8'h2f, 8'h30, 8'h6f, 8'h70};
        logic [7:0] x [10] = '{SIG_0, SIG_1, SIG_2, SIG_3, FILL, 8'hff, 8'hff, FILL, FILL, 8'hff};
        // Host reads fixed offsets from the header at 00h through the table at 30h to the reserved area at 70h
        for (int i = 0; i < 10; i++)
        begin
            run(OP_PARAM_READ, {16'h0000, a[i]}, 8'h00);
            `CHK("param byte", x[i], r)
            run(OP_SEC_READ, {16'h0000, a[i]}, 8'h00);
            `CHK("region0 byte", x[i], r)
        end
        run(OP_SEC_PROGRAM, 24'h000000, 8'h00);
        `CHK("region0 write err", 1'b1, e)
        run(OP_PARAM_READ, 24'h000000, 8'h00);
        `CHK("region0 kept", SIG_0, r)
    endtask

    // Main array: chip and sector erase, bit clearing, page independence, address decode
    task automatic t_array();
        run(OP_CHIP_ERASE, 24'h000000, 8'h00);
        `CHK("busy after erase", 1'b0, busy)
        run(OP_READ, 24'h001234, 8'h00);
        `CHK("chip erased", 8'hff, r)
        run(OP_PROGRAM, 24'h000fff, 8'h00);
        run(OP_PROGRAM, 24'h001234, 8'ha5);
        run(OP_PROGRAM, 24'h001234, 8'h0f);
        `CHK("old byte", 8'ha5, r)
        run(OP_READ, 24'hc01234, 8'h00);
        `CHK("and of writes", 8'h05, r)
        run(OP_READ, 24'h001334, 8'h00);
        `CHK("next page", 8'hff, r)
        run(OP_SECT_ERASE, 24'h001abc, 8'h00);
        run(OP_READ, 24'h001234, 8'h00);
        `CHK("sector erased", 8'hff, r)
        run(OP_READ, 24'h000fff, 8'h00);
        `CHK("prior sector", 8'h00, r)
        run(8'h81, 24'h001234, 8'h00);
        `CHK("no page erase", 1'b1, e)
    endtask

    // Security regions: independent use, one-time lock, address checks
    task automatic t_secure();
        run(OP_SEC_ERASE, 24'h002000, 8'h00);
        run(OP_SEC_PROGRAM, 24'h002010, 8'h3c);
        run(OP_SEC_LOCK, 24'h002000, 8'h00);
        `CHK("lock ok", 1'b0, e)
        run(OP_SEC_PROGRAM, 24'h002010, 8'h00);
        `CHK("locked program", 1'b1, e)
        run(OP_SEC_ERASE, 24'h002000, 8'h00);
        `CHK("locked erase", 1'b1, e)
        run(OP_SEC_READ, 24'h002010, 8'h00);
        `CHK("locked data", 8'h3c, r)
        run(OP_SEC_ERASE, 24'h001000, 8'h00);
        run(OP_SEC_PROGRAM, 24'h001011, 8'h77);
        `CHK("region1 open", 1'b0, e)
        run(OP_SEC_READ, 24'h001011, 8'h00);
        `CHK("region1 data", 8'h77, r)
        run(OP_SEC_READ, 24'h002100, 8'h00);
        `CHK("outside region", 1'b1, e)
    endtask

    task automatic final_report();
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard: the chip erase dominates the run time
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        repeat (3) @(posedge clk_link_i);  // Link side resets through a synchroniser
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(posedge clk_link_i);
        t_params();
        t_array();
        t_secure();
        final_report();
    end
endmodule // faorm_region_map_test
